// *** logic/dslc_top.sv ***
// serial load control of a 16-bit voltage-output converter
//
// Function
// - Load-latch low makes the converter latch follow the input register.
// - Converter code changes with the converter latch or with the format strap.
// - After reset the stored code is 8000h with strap high, 0000h low.
// - Format strap high means straight binary, low means two's complement.
// - Reset low clears the code registers; the strap-selected code is loaded on the third clock after release.
// - Power-down high forces the converter output to ground.
// - Bits are shifted only while chip select is low; host frames accordingly.
// - Serial output is undriven while chip select is high.
// - Readback strap high shifts out the existing input register.
// - Readback strap low shifts out the shift register for daisy chains.
`timescale 1ns/10ps
`default_nettype none
`include "dslc_params.svh"
module dslc_top
   import dslc_pkg::*;
(
   // system clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // serial link
   input  wire logic        sclk,
   input  wire logic        cs_n,
   input  wire logic        serial_in,
   output logic             serial_out,
   output logic             serial_out_en,
   // control pins and straps
   input  wire logic        latch_load_n,
   input  wire logic        reset_code_select,
   input  wire logic        input_format_select,
   input  wire logic        power_down_in,
   input  wire logic        readback_source_select,
   // converter side
   output dslc_word_t       converter_code,
   output logic             converter_power_down,
   // status
   output dslc_word_t       input_word,
   output logic             word_overrun,
   output logic             frame_ready
);

   // ---------------- link domain (sclk) ----------------
   logic       frame_rst_n;
   logic [3:0] bit_cnt_q;
   logic [3:0] bit_cnt_d;
   dslc_word_t shift_q;
   dslc_word_t shift_d;
   dslc_word_t hold_q;
   dslc_word_t hold_d;
   logic       hold_tog_q;
   logic       hold_tog_d;
   logic       out_en_q;
   logic       serial_out_q;
   logic       serial_out_d;
   dslc_word_t rb_shift_q;
   dslc_word_t rb_shift_d;
   logic       sel_s1_q;
   logic       sel_s2_q;
   logic       rbt_s1_q;
   logic       rbt_s2_q;
   logic       rbt_prev_q;
   dslc_word_t snap_q;
   dslc_word_t snap_d;

   // system-domain signals read by the link side
   logic       rb_tog_q;
   dslc_word_t input_reg_q;

   // frame state is held in reset while deselected, since sclk may stop
   // deselect gates the link
   assign frame_rst_n = rst_n & ~cs_n;

   always_comb begin
      bit_cnt_d  = bit_cnt_q + `DSLC_BIT_FIRST;
      shift_d    = {shift_q[`DSLC_WORD_W-2:0], serial_in};
      hold_d     = hold_q;
      hold_tog_d = hold_tog_q;
      if (bit_cnt_q == `DSLC_BIT_LAST) begin
         hold_d     = shift_d;
         hold_tog_d = ~hold_tog_q;
      end
      snap_d = snap_q;
      // word is stable long before its toggle is seen here
      if (rbt_s2_q != rbt_prev_q) begin
         snap_d = input_reg_q;
      end
      if (bit_cnt_q == 4'h0) begin
         rb_shift_d = {snap_q[`DSLC_WORD_W-2:0], 1'b0};
      end else begin
         rb_shift_d = {rb_shift_q[`DSLC_WORD_W-2:0], 1'b0};
      end
      if (sel_s2_q) begin
         serial_out_d = (bit_cnt_q == 4'h0) ? snap_q[`DSLC_WORD_W-1] : rb_shift_q[`DSLC_WORD_W-1];
      end else begin
         serial_out_d = shift_q[`DSLC_WORD_W-1];
      end
   end

   always_ff @(posedge sclk or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         bit_cnt_q    <= 4'h0;
         shift_q      <= `DSLC_CODE_ZERO;
         rb_shift_q   <= `DSLC_CODE_ZERO;
         out_en_q     <= 1'b0;
         serial_out_q <= 1'b0;
      end else begin
         bit_cnt_q    <= bit_cnt_d;
         shift_q      <= shift_d;
         rb_shift_q   <= rb_shift_d;
         out_en_q     <= 1'b1;
         serial_out_q <= serial_out_d;
      end
   end

   always_ff @(posedge sclk or negedge rst_n) begin
      if (!rst_n) begin
         hold_q     <= `DSLC_CODE_ZERO;
         hold_tog_q <= 1'b0;
         sel_s1_q   <= 1'b1;
         sel_s2_q   <= 1'b1;
         rbt_s1_q   <= 1'b0;
         rbt_s2_q   <= 1'b0;
         rbt_prev_q <= 1'b0;
         snap_q     <= `DSLC_CODE_ZERO;
      end else begin
         hold_q     <= hold_d;
         hold_tog_q <= hold_tog_d;
         sel_s1_q   <= readback_source_select;
         sel_s2_q   <= sel_s1_q;
         rbt_s1_q   <= rb_tog_q;
         rbt_s2_q   <= rbt_s1_q;
         rbt_prev_q <= rbt_s2_q;
         snap_q     <= snap_d;
      end
   end

   assign serial_out    = serial_out_q;
   assign serial_out_en = out_en_q;

   // ---------------- system domain (clk) ----------------
   logic         cs_s1_q;
   logic         cs_s2_q;
   logic         cs_prev_q;
   logic         tog_s1_q;
   logic         tog_s2_q;
   logic         tog_prev_q;
   logic [3:0]   strap_s1_q;
   logic [3:0]   strap_s2_q;
   logic         cs_rise;
   logic         word_evt;
   dslc_commit_e state_q;
   dslc_commit_e state_d;
   logic [1:0]   init_cnt_q;
   logic [1:0]   init_cnt_d;
   logic [2:0]   settle_cnt_q;
   logic [2:0]   settle_cnt_d;
   dslc_word_t   input_reg_d;
   dslc_word_t   latch_q;
   dslc_word_t   latch_d;
   dslc_word_t   conv_code_q;
   dslc_word_t   conv_code_d;
   logic         fmt_used_q;
   logic         conv_pd_q;
   logic         rb_tog_d;
   logic         overrun_q;
   logic         overrun_d;
   logic         frame_ready_q;
   logic         fifo_in_valid;
   logic         fifo_in_ready;
   logic         fifo_out_valid;
   logic         fifo_out_ready;
   dslc_word_t   fifo_out_data;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cs_s1_q    <= 1'b1;
         cs_s2_q    <= 1'b1;
         cs_prev_q  <= 1'b1;
         tog_s1_q   <= 1'b0;
         tog_s2_q   <= 1'b0;
         tog_prev_q <= 1'b0;
         strap_s1_q <= `DSLC_STRAP_RESET;
         strap_s2_q <= `DSLC_STRAP_RESET;
      end else begin
         cs_s1_q    <= cs_n;
         cs_s2_q    <= cs_s1_q;
         cs_prev_q  <= cs_s2_q;
         tog_s1_q   <= hold_tog_q;
         tog_s2_q   <= tog_s1_q;
         tog_prev_q <= tog_s2_q;
         strap_s1_q <= {latch_load_n, power_down_in, input_format_select, reset_code_select};
         strap_s2_q <= strap_s1_q;
      end
   end

   assign cs_rise  = cs_s2_q & ~cs_prev_q;
   assign word_evt = tog_s2_q ^ tog_prev_q;
   // words are buffered until the frame end; a full buffer drops and flags
   assign fifo_in_valid  = word_evt && (state_q != DSLC_ST_INIT);
   assign fifo_out_ready = (state_q == DSLC_ST_DRAIN);

   dslc_fifo #(
      .W     (`DSLC_WORD_W),
      .DEPTH (`DSLC_FIFO_DEPTH)
   ) u_fifo (
      .clk       (clk),
      .rst_n     (rst_n),
      .in_valid  (fifo_in_valid),
      .in_ready  (fifo_in_ready),
      .in_data   (hold_q),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_out_ready),
      .out_data  (fifo_out_data)
   );

   always_comb begin
      state_d      = state_q;
      init_cnt_d   = init_cnt_q;
      settle_cnt_d = settle_cnt_q;
      input_reg_d  = input_reg_q;
      rb_tog_d     = rb_tog_q;
      latch_d      = latch_q;
      case (state_q)
         DSLC_ST_INIT: begin
            init_cnt_d = init_cnt_q + 2'h1;
            // strap caught after release
            // third edge: the two-flop strap copy is only valid from here
            // full reset to strap code
            if (init_cnt_q == `DSLC_INIT_LAST) begin
               input_reg_d = dslc_reset_code(strap_s2_q[`DSLC_STRAP_RSEL]);
               latch_d     = input_reg_d;
               rb_tog_d    = ~rb_tog_q;
               state_d     = DSLC_ST_IDLE;
            end
         end
         DSLC_ST_IDLE: begin
            if (cs_rise) begin
               settle_cnt_d = 3'h0;
               state_d      = DSLC_ST_SETTLE;
            end
         end
         DSLC_ST_SETTLE: begin
            // wait out the word crossing that trails the last sclk edge
            settle_cnt_d = settle_cnt_q + 3'h1;
            if (cs_rise) begin
               settle_cnt_d = 3'h0;
            end else if (settle_cnt_q == `DSLC_SETTLE_LAST) begin
               state_d = DSLC_ST_DRAIN;
            end
         end
         DSLC_ST_DRAIN: begin
            // commit, last word of the frame wins
            if (fifo_out_valid) begin
               input_reg_d = fifo_out_data;
            end
            if (cs_rise) begin
               settle_cnt_d = 3'h0;
               state_d      = DSLC_ST_SETTLE;
            end else if (!fifo_out_valid) begin
               // one toggle per drain: back-to-back pops would cancel in the slow link domain
               rb_tog_d = ~rb_tog_q;
               state_d  = DSLC_ST_IDLE;
            end
         end
         default: begin
            state_d = DSLC_ST_INIT;
         end
      endcase
      if ((state_q != DSLC_ST_INIT) && !strap_s2_q[`DSLC_STRAP_LDN]) begin
         latch_d = input_reg_q;
      end
      conv_code_d = dslc_to_offset(latch_d, strap_s2_q[`DSLC_STRAP_FMT]);
      // set wins over the frame-end clear
      overrun_d = (fifo_in_valid && !fifo_in_ready) || (overrun_q && !cs_rise);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q       <= DSLC_ST_INIT;
         init_cnt_q    <= 2'h0;
         settle_cnt_q  <= 3'h0;
         input_reg_q   <= `DSLC_CODE_ZERO;
         rb_tog_q      <= 1'b0;
         latch_q       <= `DSLC_CODE_ZERO;
         conv_code_q   <= `DSLC_CODE_ZERO;
         fmt_used_q    <= 1'b1;
         conv_pd_q     <= 1'b1;
         overrun_q     <= 1'b0;
         frame_ready_q <= 1'b0;
      end else begin
         state_q       <= state_d;
         init_cnt_q    <= init_cnt_d;
         settle_cnt_q  <= settle_cnt_d;
         input_reg_q   <= input_reg_d;
         rb_tog_q      <= rb_tog_d;
         latch_q       <= latch_d;
         conv_code_q   <= conv_code_d;
         fmt_used_q    <= strap_s2_q[`DSLC_STRAP_FMT];
         conv_pd_q     <= strap_s2_q[`DSLC_STRAP_PDN];
         overrun_q     <= overrun_d;
         frame_ready_q <= fifo_in_ready;
      end
   end

   assign converter_code       = conv_code_q;
   assign converter_power_down = conv_pd_q;
   assign input_word           = input_reg_q;
   assign word_overrun         = overrun_q;
   assign frame_ready          = frame_ready_q;

   // ---------------- checks ----------------
   sequence init_load_s;
      (state_q == DSLC_ST_INIT) ##1 (state_q == DSLC_ST_IDLE);
   endsequence

   sequence pd_held_s;
      $rose(power_down_in) ##1 power_down_in [*3];
   endsequence

   chk_latch_follow: assert property (
      @(posedge clk) disable iff (!rst_n)
      ((state_q != DSLC_ST_INIT) && !strap_s2_q[`DSLC_STRAP_LDN]) |=> (latch_q == $past(input_reg_q)))
      else $error("latch did not follow input register while load-latch low");

   chk_code_with_latch: assert property (
      @(posedge clk) disable iff (!rst_n)
      (conv_code_q == dslc_to_offset(latch_q, fmt_used_q)))
      else $error("converter code out of step with latch");

   chk_reset_code: assert property (
      @(posedge clk) disable iff (!rst_n)
      init_load_s |-> (input_reg_q == dslc_reset_code($past(strap_s2_q[`DSLC_STRAP_RSEL]))))
      else $error("wrong reset code after reset");

   chk_straight_pass: assert property (
      @(posedge clk) disable iff (!rst_n)
      fmt_used_q |-> (conv_code_q == latch_q))
      else $error("straight binary word altered");

   chk_reset_sequence: assert property (
      @(posedge clk) disable iff (!rst_n)
      ((state_q == DSLC_ST_INIT) && (init_cnt_q == 2'h0)) |-> (state_q == DSLC_ST_INIT) ##3 (state_q == DSLC_ST_IDLE))
      else $error("reset load took the wrong number of cycles");

   chk_power_down: assert property (
      @(posedge clk) disable iff (!rst_n)
      pd_held_s |-> conv_pd_q)
      else $error("power-down pin not reflected at the converter");

   chk_shift_gate: assert property (
      @(posedge sclk) disable iff (!frame_rst_n)
      out_en_q |-> ((shift_q[0] == $past(serial_in)) && (bit_cnt_q == $past(bit_cnt_q) + `DSLC_BIT_FIRST)))
      else $error("shift register did not take the serial bit");

   chk_out_released: assert property (
      @(posedge clk) disable iff (!rst_n)
      cs_n |-> !out_en_q)
      else $error("serial output driven while deselected");

   chk_standalone_out: assert property (
      @(posedge sclk) disable iff (!frame_rst_n)
      ($past(sel_s2_q) && (bit_cnt_q == `DSLC_BIT_FIRST)) |-> (serial_out_q == $past(snap_q[`DSLC_WORD_W-1])))
      else $error("stand-alone readback did not start with register msb");

   chk_daisy_out: assert property (
      @(posedge sclk) disable iff (!frame_rst_n)
      (!$past(sel_s2_q) && out_en_q) |-> (serial_out_q == $past(shift_q[`DSLC_WORD_W-1])))
      else $error("daisy output is not the shifted-out bit");

   chk_word_commit: assert property (
      @(posedge clk) disable iff (!rst_n)
      ((state_q == DSLC_ST_DRAIN) && fifo_out_valid) |=> (input_reg_q == $past(fifo_out_data)))
      else $error("received word not committed to input register");

   chk_msb_invert: assert property (
      @(posedge clk) disable iff (!rst_n)
      !fmt_used_q |-> ((conv_code_q[`DSLC_WORD_W-1] != latch_q[`DSLC_WORD_W-1])
                       && (conv_code_q[`DSLC_WORD_W-2:0] == latch_q[`DSLC_WORD_W-2:0])))
      else $error("two's complement msb not inverted");

endmodule
`default_nettype wire

// *** logic/dslc_params.svh ***
// timing counts, reset codes and field constants of the serial-load converter front end
`ifndef DSLC_PARAMS_SVH
`define DSLC_PARAMS_SVH

`define DSLC_WORD_W        16
`define DSLC_CODE_MID      16'h8000
`define DSLC_CODE_ZERO     16'h0000
`define DSLC_MSB_FLIP      16'h8000
`define DSLC_BIT_LAST      4'hF
`define DSLC_BIT_FIRST     4'h1
`define DSLC_FIFO_DEPTH    8
`define DSLC_CLK_MHZ       50
`define DSLC_SETTLE_NS     80
`define DSLC_SETTLE_CYC    (((`DSLC_SETTLE_NS * `DSLC_CLK_MHZ) + 999) / 1000)
`define DSLC_SETTLE_LAST   3'((`DSLC_SETTLE_CYC) - 1)
`define DSLC_INIT_LAST     2'h2
`define DSLC_STRAP_RSEL    0
`define DSLC_STRAP_FMT     1
`define DSLC_STRAP_PDN     2
`define DSLC_STRAP_LDN     3
`define DSLC_STRAP_RESET   4'h8

`endif

// *** logic/dslc_pkg.sv ***
// types and code conversion shared by the converter front end
`default_nettype none
package dslc_pkg;
`include "dslc_params.svh"

   typedef logic [`DSLC_WORD_W-1:0] dslc_word_t;

   typedef enum logic [1:0] {
      DSLC_ST_INIT   = 2'b00,
      DSLC_ST_IDLE   = 2'b01,
      DSLC_ST_SETTLE = 2'b10,
      DSLC_ST_DRAIN  = 2'b11
   } dslc_commit_e;

   // straight binary passes, two's complement flips the top bit into offset binary
   function automatic dslc_word_t dslc_to_offset(input dslc_word_t word, input logic straight);
      dslc_to_offset = straight ? word : (word ^ `DSLC_MSB_FLIP);
   endfunction

   function automatic dslc_word_t dslc_reset_code(input logic mid_sel);
      dslc_reset_code = mid_sel ? `DSLC_CODE_MID : `DSLC_CODE_ZERO;
   endfunction

endpackage
`default_nettype wire

// *** logic/dslc_fifo.sv ***
// small synchronous word fifo with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module dslc_fifo #(
   parameter int W     = 16,
   parameter int DEPTH = 8
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // fill side
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   // drain side
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [W-1:0] mem_q [DEPTH];
   logic [AW:0]  wr_q;
   logic [AW:0]  wr_d;
   logic [AW:0]  rd_q;
   logic [AW:0]  rd_d;
   logic         push;
   logic         pop;

   always_comb begin
      in_ready  = !((wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]));
      out_valid = (wr_q != rd_q);
      out_data  = mem_q[rd_q[AW-1:0]];
      push      = in_valid && in_ready;
      pop       = out_valid && out_ready;
      wr_d      = wr_q + {{AW{1'b0}}, push};
      rd_d      = rd_q + {{AW{1'b0}}, pop};
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         wr_q <= wr_d;
         rd_q <= rd_d;
      end
   end

   // storage carries no reset; only the pointers decide what is valid
   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wr_q[AW-1:0]] <= in_data;
      end
   end

endmodule
`default_nettype wire

// *** sim/dslc_host_model.sv ***
// serial host model that frames words into the converter front end
`timescale 1ns/10ps
`default_nettype none
module dslc_host_model (
   // link pins
   output logic      sclk,
   output logic      cs_n,
   output logic      serial_in,
   input  wire logic serial_out,
   input  wire logic serial_out_en
);
   logic [511:0] rx_bits;
   int           en_low;

   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      serial_in = 1'b0;
      rx_bits = '0;
      en_low = 0;
   end

   // select low over whole frame, 16-bit words msb first
   task automatic send(input logic [15:0] w [12], input int n);
      int i;
      rx_bits = '0;
      en_low = 0;
      #5 cs_n = 1'b0;
      for (i = 0; i < 16 * n; i++) begin
         serial_in = w[i / 16][15 - (i % 16)];
         #32 sclk = 1'b1;
         #32 sclk = 1'b0;
         rx_bits[i] = serial_out;
         if (serial_out_en !== 1'b1) en_low++;
      end
      #16 cs_n = 1'b1;
      // released line must not keep looking like data
      serial_in = ~serial_in;
   endtask

   // stray clocks with select high, only when the bench asks
   task automatic stray(input logic [15:0] v);
      int i;
      for (i = 0; i < 16; i++) begin
         serial_in = v[15 - i];
         #32 sclk = 1'b1;
         #32 sclk = 1'b0;
      end
      serial_in = ~serial_in;
   endtask
endmodule
`default_nettype wire

// *** sim/dslc_top_tb_top.sv ***
// self-checking bench of the serial-load converter front end
`timescale 1ns/10ps
`default_nettype none
module dslc_top_tb_top;
   import dslc_pkg::*;
   logic        clk;
   logic        rst_n;
   logic        latch_load_n;
   logic        reset_code_select;
   logic        input_format_select;
   logic        power_down_in;
   logic        readback_source_select;
   logic        sclk;
   logic        cs_n;
   logic        serial_in;
   logic        serial_out;
   logic        serial_out_en;
   logic        converter_power_down;
   logic        word_overrun;
   logic        frame_ready;
   dslc_word_t  converter_code;
   dslc_word_t  input_word;
   logic [15:0] wq [12];
   logic [15:0] w;
   logic [15:0] w2;
   logic [31:0] seed;
   int          error_cnt;
   int          n_checks;
   int          cyc;
   int          k;

   dslc_top dut_u (.clk(clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .serial_in(serial_in),
      .serial_out(serial_out), .serial_out_en(serial_out_en), .latch_load_n(latch_load_n),
      .reset_code_select(reset_code_select), .input_format_select(input_format_select),
      .power_down_in(power_down_in), .readback_source_select(readback_source_select),
      .converter_code(converter_code), .converter_power_down(converter_power_down),
      .input_word(input_word), .word_overrun(word_overrun), .frame_ready(frame_ready));

   dslc_host_model host_u (.sclk(sclk), .cs_n(cs_n), .serial_in(serial_in),
      .serial_out(serial_out), .serial_out_en(serial_out_en));

   always #10 clk = ~clk;

   function automatic logic [15:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[15:0];
   endfunction

   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   // commit takes about eight clocks after select rises; bounded wait
   task automatic wait_word(input logic [15:0] exp);
      int i;
      for (i = 0; i < 40 && input_word !== exp; i++) @(negedge clk);
      repeat (12) @(negedge clk);
   endtask

   task automatic write1(input logic [15:0] v);
      wq[0] = v;
      host_u.send(wq, 1);
      @(negedge clk);
      wait_word(v);
   endtask

   always @(posedge clk) begin
      cyc++;
      if (cyc > 20000) begin
         error_cnt++;
         print_verdict();
      end
   end

   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      latch_load_n = 1'b0;
      reset_code_select = 1'b1;
      input_format_select = 1'b1;
      power_down_in = 1'b0;
      readback_source_select = 1'b1;
      seed = 32'h3B89;
      error_cnt = 0;
      n_checks = 0;
      cyc = 0;
      repeat (10) @(negedge clk);
      rst_n = 1'b1;
      repeat (6) @(negedge clk);
      check("reset word", 16'h8000, input_word);
      check("reset converter", 16'h8000, converter_code);
      check("power down idle", 16'h0000, {15'h0000, converter_power_down});
      $display("test reset done");
      for (k = 0; k < 6; k++) begin
         w = (k == 0) ? 16'hFFFF : (k == 1) ? 16'h0000 : rnd();
         write1(w);
         check("input word", w, input_word);
         check("latch follows", w, converter_code);
      end
      latch_load_n = 1'b1;
      w2 = ~w;
      write1(w2);
      check("latch held", w, converter_code);
      latch_load_n = 1'b0;
      repeat (5) @(negedge clk);
      check("latch loaded", w2, converter_code);
      input_format_select = 1'b0;
      repeat (5) @(negedge clk);
      check("twos converter", w2 ^ 16'h8000, converter_code);
      write1(16'h7FFF);
      check("twos raw word", 16'h7FFF, input_word);
      check("twos max", 16'hFFFF, converter_code);
      input_format_select = 1'b1;
      power_down_in = 1'b1;
      repeat (5) @(negedge clk);
      check("power down on", 16'h0001, {15'h0000, converter_power_down});
      power_down_in = 1'b0;
      repeat (5) @(negedge clk);
      check("power down off", 16'h0000, {15'h0000, converter_power_down});
      $display("test load and format done");
      w = rnd();
      write1(w);
      write1(w);
      write1(w);
      w2 = {<<{w}};
      check("readback", w2, host_u.rx_bits[15:0]);
      check("enable in frame", 16'h0000, 16'(host_u.en_low));
      check("enable idle", 16'h0000, {15'h0000, serial_out_en});
      host_u.stray(~w);
      repeat (15) @(negedge clk);
      check("stray clocks", w, input_word);
      $display("test readback done");
      readback_source_select = 1'b0;
      // the strap reaches the link side only on sclk edges
      host_u.stray(16'h0000);
      repeat (4) @(negedge clk);
      wq[0] = rnd();
      wq[1] = rnd();
      host_u.send(wq, 2);
      w2 = {<<{wq[0]}};
      check("daisy lead", 16'h0000, host_u.rx_bits[15:0]);
      check("daisy pass", w2, host_u.rx_bits[31:16]);
      @(negedge clk);
      wait_word(wq[1]);
      check("daisy commit", wq[1], input_word);
      $display("test daisy done");
      readback_source_select = 1'b1;
      for (k = 0; k < 10; k++) wq[k] = rnd();
      fork
         host_u.send(wq, 10);
         for (k = 0; k < 700 && word_overrun !== 1'b1; k++) @(negedge clk);
      join_any
      check("overrun", 16'h0001, {15'h0000, word_overrun});
      check("fifo full", 16'h0000, {15'h0000, frame_ready});
      wait fork;
      @(negedge clk);
      wait_word(wq[7]);
      check("drained word", wq[7], input_word);
      check("fifo free", 16'h0001, {15'h0000, frame_ready});
      $display("test overrun done");
      reset_code_select = 1'b0;
      rst_n = 1'b0;
      repeat (3) @(negedge clk);
      rst_n = 1'b1;
      repeat (6) @(negedge clk);
      check("rereset word", 16'h0000, input_word);
      check("rereset converter", 16'h0000, converter_code);
      $display("test second reset done");
      print_verdict();
   end
endmodule
`default_nettype wire
